// ---- tcch_defs.svh ----
`ifndef TCCH_DEFS_SVH
`define TCCH_DEFS_SVH
// ==============================================
// Packet framing
`define TCCH_HEADER 8'h55
`define TCCH_RSP_SIZE_BASE 8'h02
`define TCCH_RSP_SIZE_BASEADDR 8'h03
`define TCCH_RX_BUF_LEN 12
// ==============================================
// Command identifiers
`define TCCH_CMD_CALIBRATE 8'h14
`define TCCH_CMD_REG_READ 8'h20
`define TCCH_CMD_REG_WRITE 8'h21
`define TCCH_CMD_BASE_QUERY 8'h22
`define TCCH_CMD_CONFIG_SAVE 8'h23
`define TCCH_CMD_NVM_READ 8'h28
`define TCCH_CAL_TYPE_4PT 8'h04
// ==============================================
// Status codes
`define TCCH_ST_OK 8'h00
`define TCCH_ST_BAD_CMD 8'h01
`define TCCH_ST_BAD_HDR 8'h03
`define TCCH_ST_TIMEOUT 8'h04
// ==============================================
// Counts and limits
`define TCCH_CNT_MIN 8'h01
`define TCCH_CNT_MAX 8'h08
`define TCCH_CAL_POINTS 3'h4
`define TCCH_CAL_BLOCK_LEN 8'h12
`define TCCH_COORD_SHIFT 6
// ==============================================
// Register group and memory layout
`define TCCH_REG_BASE 8'h20
`define TCCH_CFG_LEN 8'h20
`define TCCH_CFG_MARGIN_OFS 5'h0F
`define TCCH_NVM_CFG_BASE 8'h00
`define TCCH_NVM_CAL_BASE 8'h40
`define TCCH_CAL_SEPARATOR 8'hA5
// ==============================================
// Timing
`define TCCH_CLK_KHZ 125000
`define TCCH_TIMEOUT_MS 100
`endif

// ---- tcch_pkg.sv ----
package tcch_pkg;
    // Command state, Gray coded along the usual path
    typedef enum logic [2:0] {
        TCCH_IDLE = 3'b000,
        TCCH_SIZE = 3'b001,
        TCCH_BODY = 3'b011,
        TCCH_EXEC = 3'b010,
        TCCH_SEND = 3'b110,
        TCCH_CALW = 3'b111,
        TCCH_STORE = 3'b101
    } tcch_state_e;
endpackage

// ---- tcch_span.sv ----
`timescale 1ns/10ps
// ==============================================
// Extent of four coordinates, widened by a margin
module tcch_span (
    input wire logic [9:0] v0_i,
    input wire logic [9:0] v1_i,
    input wire logic [9:0] v2_i,
    input wire logic [9:0] v3_i,
    input wire logic [7:0] margin_i,
    output logic [9:0] lo_o,
    output logic [9:0] hi_o
);
    logic [9:0] mn;
    logic [9:0] mx;
    logic [10:0] up;

    // Saturate so a large margin never wraps the corner
    always_comb
    begin
        mn = v0_i;
        mx = v0_i;
        if (v1_i < mn) mn = v1_i;
        if (v2_i < mn) mn = v2_i;
        if (v3_i < mn) mn = v3_i;
        if (v1_i > mx) mx = v1_i;
        if (v2_i > mx) mx = v2_i;
        if (v3_i > mx) mx = v3_i;
        up = {1'b0, mx} + {3'b000, margin_i};
        lo_o = (mn > {2'b00, margin_i}) ? mn - {2'b00, margin_i} : 10'h000;
        hi_o = up[10] ? 10'h3FF : up[9:0];
    end
endmodule

// ---- tcch_timer.sv ----
`timescale 1ns/10ps
// ==============================================
// Reception watchdog, one pulse when the budget runs out
module tcch_timer #(
    parameter int CYCLES = 12500000
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic restart_i,
    output logic expire_o
);
    logic [31:0] cnt_reg;

    // Counter held at zero while idle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= 32'h00000000;
            expire_o <= 1'b0;
        end
        else
        begin
            expire_o <= 1'b0;
            if (!run_i || restart_i)
                cnt_reg <= 32'h00000000;
            else if (cnt_reg == 32'(CYCLES - 1))
            begin
                cnt_reg <= 32'h00000000;
                expire_o <= 1'b1;
            end
            else
                cnt_reg <= cnt_reg + 32'h00000001;
        end
    end
endmodule

// ---- tcch_handler.sv ----
// How it works
// - Calibrate request is acknowledged with 55, 02, success, 14.
// - Successful calibration sends six packets: acknowledge, four touches, completion.
// - Non-zero margin pushes the captured extremes outward before storing.
// - Corners reordered: upper-left is minimum X,Y; lower-right is maximum.
// - Each coordinate stored shifted left six, as low then high byte.
// - Block is separator, UL, UR, LR, LL (X then Y, low first), flip.
// - Flip bits 7..3 read zero; bit 2 marks swapped axes.
// - Flip bit 1 marks a mirrored X axis.
// - Flip bit 0 marks a mirrored Y axis.
// - Register read answer has size two plus count, status, command, values.
// - Address high byte of register requests is ignored.
// - Register write carries data bytes; answer is 55, 02, status, 21.
// - Base query answers size three, status, 22, base address.
// - Save command copies configuration registers into memory, answers 02, status, 23.
// - Memory holds 256 bytes; upper half belongs to the user.
// - Memory read ignores high address, answers size two plus count and data.
// - Status codes: 00 success, 01 bad command, 03 bad header, 04 timeout.
// - Every packet starts with 55 and a size counting following bytes.
`timescale 1ns/10ps
`include "tcch_defs.svh"
module tcch_handler #(
    parameter int TIMEOUT_CYCLES = `TCCH_TIMEOUT_MS * `TCCH_CLK_KHZ,
    parameter logic [7:0] REG_BASE = `TCCH_REG_BASE
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic touch_valid_i,
    input wire logic [9:0] touch_x_i,
    input wire logic [9:0] touch_y_i,
    output logic calibrating_o,
    output logic axis_swap_flag_o,
    output logic horizontal_mirror_flag_o,
    output logic vertical_mirror_flag_o
);
    tcch_pkg::tcch_state_e state_reg;
    logic [7:0] rx_buf [0:`TCCH_RX_BUF_LEN-1];
    logic [7:0] size_reg;
    logic [7:0] got_reg;
    logic [7:0] cfg_mem [0:`TCCH_CFG_LEN-1];
    logic [7:0] nvm_mem [0:255];
    logic [7:0] rsp_status_reg;
    logic [7:0] rsp_cmd_reg;
    logic [7:0] rsp_size_reg;
    logic [7:0] rsp_addr_reg;
    logic [7:0] tx_idx_reg;
    logic [9:0] px_reg [0:3];
    logic [9:0] py_reg [0:3];
    logic [2:0] npt_reg;
    logic [1:0] cal_phase_reg;
    logic st_cal_reg;
    logic [7:0] st_idx_reg;
    logic [7:0] calibration_axis_flip_reg;
    logic [9:0] xlo, xhi, ylo, yhi;
    logic expire;
    logic [7:0] cmd, cnt, addr_lo, reg_idx, next_byte, cal_byte, st_byte;
    logic cnt_ok, tx_take, last_byte;
    logic [15:0] c16;
    logic [9:0] dx, dy;

    assign cmd = rx_buf[0];
    assign addr_lo = rx_buf[2];  // High byte rx_buf[1] never read
    assign cnt = rx_buf[3];
    assign reg_idx = addr_lo - REG_BASE;
    assign cnt_ok = (cnt >= `TCCH_CNT_MIN) && (cnt <= `TCCH_CNT_MAX);
    assign tx_take = !tx_valid_o || tx_ready_i;
    assign last_byte = (tx_idx_reg == rsp_size_reg + 8'h01);

    // ==============================================
    // Extent of the captured corners
    tcch_span u_span_x (
        .v0_i(px_reg[0]),
        .v1_i(px_reg[1]),
        .v2_i(px_reg[2]),
        .v3_i(px_reg[3]),
        .margin_i(cfg_mem[`TCCH_CFG_MARGIN_OFS]),
        .lo_o(xlo),
        .hi_o(xhi)
    );
    tcch_span u_span_y (
        .v0_i(py_reg[0]),
        .v1_i(py_reg[1]),
        .v2_i(py_reg[2]),
        .v3_i(py_reg[3]),
        .margin_i(cfg_mem[`TCCH_CFG_MARGIN_OFS]),
        .lo_o(ylo),
        .hi_o(yhi)
    );
    tcch_timer #(
        .CYCLES(TIMEOUT_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(state_reg == tcch_pkg::TCCH_SIZE || state_reg == tcch_pkg::TCCH_BODY),
        .restart_i(rx_valid_i),
        .expire_o(expire)
    );

    // ==============================================
    // Calibration block byte, corners rebuilt from the extent
    always_comb
    begin
        c16 = 16'h0000;
        cal_byte = `TCCH_CAL_SEPARATOR;
        case (st_idx_reg[4:2] - 3'h0)
            3'd0: c16 = 16'h0000;
            default: c16 = 16'h0000;
        endcase
        case (st_idx_reg)
            8'd1, 8'd2: c16 = {xlo, 6'h00};     // UL X
            8'd3, 8'd4: c16 = {ylo, 6'h00};     // UL Y
            8'd5, 8'd6: c16 = {xhi, 6'h00};     // UR X
            8'd7, 8'd8: c16 = {ylo, 6'h00};     // UR Y
            8'd9, 8'd10: c16 = {xhi, 6'h00};    // LR X
            8'd11, 8'd12: c16 = {yhi, 6'h00};   // LR Y
            8'd13, 8'd14: c16 = {xlo, 6'h00};   // LL X
            8'd15, 8'd16: c16 = {yhi, 6'h00};   // LL Y
            default: c16 = 16'h0000;
        endcase
        if (st_idx_reg == 8'd0)
            cal_byte = `TCCH_CAL_SEPARATOR;
        else if (st_idx_reg == `TCCH_CAL_BLOCK_LEN - 8'h01)
            cal_byte = calibration_axis_flip_reg;
        else
            cal_byte = st_idx_reg[0] ? c16[7:0] : c16[15:8];  // Low first
        st_byte = st_cal_reg ? cal_byte : cfg_mem[st_idx_reg[4:0]];
    end

    // ==============================================
    // Next outgoing byte from the response fields
    always_comb
    begin
        case (tx_idx_reg)
            8'd0: next_byte = `TCCH_HEADER;
            8'd1: next_byte = rsp_size_reg;
            8'd2: next_byte = rsp_status_reg;
            8'd3: next_byte = rsp_cmd_reg;
            default:
            begin
                if (rsp_cmd_reg == `TCCH_CMD_BASE_QUERY)
                    next_byte = REG_BASE;
                else if (rsp_cmd_reg == `TCCH_CMD_NVM_READ)
                    next_byte = nvm_mem[rsp_addr_reg + tx_idx_reg - 8'h04];
                else if ((rsp_addr_reg + tx_idx_reg - 8'h04) < `TCCH_CFG_LEN)
                    next_byte = cfg_mem[5'(rsp_addr_reg + tx_idx_reg - 8'h04)];
                else
                    next_byte = 8'h00;
            end
        endcase
    end

    // ==============================================
    // Orientation of the raw touches, first two set the axis
    assign dx = (px_reg[1] > px_reg[0]) ? px_reg[1] - px_reg[0] : px_reg[0] - px_reg[1];
    assign dy = (py_reg[1] > py_reg[0]) ? py_reg[1] - py_reg[0] : py_reg[0] - py_reg[1];

    // ==============================================
    // Main command sequencer
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= tcch_pkg::TCCH_IDLE;
            size_reg <= 8'h00;
            got_reg <= 8'h00;
            rsp_status_reg <= `TCCH_ST_OK;
            rsp_cmd_reg <= 8'h00;
            rsp_size_reg <= `TCCH_RSP_SIZE_BASE;
            rsp_addr_reg <= 8'h00;
            tx_idx_reg <= 8'h00;
            tx_valid_o <= 1'b0;
            tx_data_o <= 8'h00;
            npt_reg <= 3'h0;
            cal_phase_reg <= 2'h0;
            st_cal_reg <= 1'b0;
            st_idx_reg <= 8'h00;
            calibrating_o <= 1'b0;
        end
        else
        begin
            if (tx_valid_o && tx_ready_i)
                tx_valid_o <= 1'b0;
            case (state_reg)
                tcch_pkg::TCCH_IDLE:
                begin
                    if (rx_valid_i && rx_data_i == `TCCH_HEADER)
                        state_reg <= tcch_pkg::TCCH_SIZE;
                    else if (rx_valid_i)
                    begin
                        rsp_status_reg <= `TCCH_ST_BAD_HDR;
                        rsp_cmd_reg <= rx_data_i;
                        rsp_size_reg <= `TCCH_RSP_SIZE_BASE;
                        tx_idx_reg <= 8'h00;
                        state_reg <= tcch_pkg::TCCH_SEND;
                    end
                end
                tcch_pkg::TCCH_SIZE:
                begin
                    got_reg <= 8'h00;
                    if (expire)
                    begin
                        rsp_status_reg <= `TCCH_ST_TIMEOUT;
                        rsp_cmd_reg <= 8'h00;
                        rsp_size_reg <= `TCCH_RSP_SIZE_BASE;
                        tx_idx_reg <= 8'h00;
                        state_reg <= tcch_pkg::TCCH_SEND;
                    end
                    else if (rx_valid_i)
                    begin
                        size_reg <= rx_data_i;
                        state_reg <= (rx_data_i == 8'h00) ? tcch_pkg::TCCH_EXEC
                                                          : tcch_pkg::TCCH_BODY;
                    end
                end
                tcch_pkg::TCCH_BODY:
                begin
                    if (expire)
                    begin
                        rsp_status_reg <= `TCCH_ST_TIMEOUT;
                        rsp_cmd_reg <= cmd;
                        rsp_size_reg <= `TCCH_RSP_SIZE_BASE;
                        tx_idx_reg <= 8'h00;
                        state_reg <= tcch_pkg::TCCH_SEND;
                    end
                    else if (rx_valid_i)
                    begin
                        got_reg <= got_reg + 8'h01;
                        if (got_reg + 8'h01 == size_reg)
                            state_reg <= tcch_pkg::TCCH_EXEC;
                    end
                end
                tcch_pkg::TCCH_EXEC:
                begin
                    // Default answer: bare status packet
                    rsp_cmd_reg <= cmd;
                    rsp_status_reg <= `TCCH_ST_OK;
                    rsp_size_reg <= `TCCH_RSP_SIZE_BASE;
                    rsp_addr_reg <= addr_lo;
                    tx_idx_reg <= 8'h00;
                    state_reg <= tcch_pkg::TCCH_SEND;
                    case (cmd)
                        `TCCH_CMD_CALIBRATE:
                        begin
                            npt_reg <= 3'h0;            // Ack first
                            cal_phase_reg <= 2'h1;
                            calibrating_o <= 1'b1;
                        end
                        `TCCH_CMD_REG_READ, `TCCH_CMD_NVM_READ:
                        begin
                            if (!cnt_ok)
                                rsp_status_reg <= `TCCH_ST_BAD_CMD;
                            else
                                rsp_size_reg <= `TCCH_RSP_SIZE_BASE + cnt;
                            if (cmd == `TCCH_CMD_REG_READ)
                                rsp_addr_reg <= reg_idx;
                        end
                        `TCCH_CMD_REG_WRITE:
                        begin
                            if (!cnt_ok)
                                rsp_status_reg <= `TCCH_ST_BAD_CMD;
                        end
                        `TCCH_CMD_BASE_QUERY:
                            rsp_size_reg <= `TCCH_RSP_SIZE_BASEADDR;
                        `TCCH_CMD_CONFIG_SAVE:
                        begin
                            st_cal_reg <= 1'b0;         // Copy then answer
                            st_idx_reg <= 8'h00;
                            state_reg <= tcch_pkg::TCCH_STORE;
                        end
                        default:
                            rsp_status_reg <= `TCCH_ST_BAD_CMD;
                    endcase
                end
                tcch_pkg::TCCH_SEND:
                begin
                    if (tx_take)
                    begin
                        tx_valid_o <= 1'b1;
                        tx_data_o <= next_byte;
                        tx_idx_reg <= tx_idx_reg + 8'h01;
                        if (last_byte)
                            state_reg <= (cal_phase_reg == 2'h1) ? tcch_pkg::TCCH_CALW
                                                                 : tcch_pkg::TCCH_IDLE;
                        if (last_byte && cal_phase_reg == 2'h2)
                        begin
                            cal_phase_reg <= 2'h0;
                            calibrating_o <= 1'b0;
                        end
                    end
                end
                tcch_pkg::TCCH_CALW:
                begin
                    // Any new command abandons calibration
                    if (rx_valid_i && rx_data_i == `TCCH_HEADER)
                    begin
                        cal_phase_reg <= 2'h0;
                        calibrating_o <= 1'b0;
                        state_reg <= tcch_pkg::TCCH_SIZE;
                    end
                    else if (touch_valid_i)
                    begin
                        npt_reg <= npt_reg + 3'h1;
                        tx_idx_reg <= 8'h00;
                        rsp_size_reg <= `TCCH_RSP_SIZE_BASE;
                        rsp_cmd_reg <= `TCCH_CMD_CALIBRATE;
                        state_reg <= tcch_pkg::TCCH_SEND;   // Touch packets
                        if (npt_reg == `TCCH_CAL_POINTS - 3'h1)
                        begin
                            cal_phase_reg <= 2'h2;          // Fourth touch: store next
                            st_cal_reg <= 1'b1;
                            st_idx_reg <= 8'h00;
                        end
                    end
                end
                tcch_pkg::TCCH_STORE:
                begin
                    st_idx_reg <= st_idx_reg + 8'h01;
                    if (st_idx_reg == (st_cal_reg ? `TCCH_CAL_BLOCK_LEN : `TCCH_CFG_LEN) - 8'h01)
                    begin
                        tx_idx_reg <= 8'h00;
                        state_reg <= tcch_pkg::TCCH_SEND;   // Completion packet
                    end
                end
                default:
                    state_reg <= tcch_pkg::TCCH_IDLE;
            endcase
            // Fourth touch packet goes out, then the store runs
            if (state_reg == tcch_pkg::TCCH_SEND && tx_take && last_byte
                && cal_phase_reg == 2'h2 && st_cal_reg && st_idx_reg == 8'h00)
            begin
                cal_phase_reg <= 2'h2;
                calibrating_o <= 1'b1;
                state_reg <= tcch_pkg::TCCH_STORE;
                st_idx_reg <= 8'h00;
                st_cal_reg <= 1'b1;  // Store the calibration block, not the config
            end
        end
    end

    // ==============================================
    // Packet bytes kept for decoding, no reset needed
    always_ff @(posedge clk_i)
    begin
        if (rx_valid_i && state_reg == tcch_pkg::TCCH_BODY && got_reg < `TCCH_RX_BUF_LEN)
            rx_buf[got_reg[3:0]] <= rx_data_i;
    end

    // ==============================================
    // Raw touch capture during calibration
    always_ff @(posedge clk_i)
    begin
        if (state_reg == tcch_pkg::TCCH_CALW && touch_valid_i && !rx_valid_i)
        begin
            px_reg[npt_reg[1:0]] <= touch_x_i;
            py_reg[npt_reg[1:0]] <= touch_y_i;
        end
    end

    // ==============================================
    // Configuration registers, written only with a legal count
    always_ff @(posedge clk_i)
    begin
        if (state_reg == tcch_pkg::TCCH_EXEC && cmd == `TCCH_CMD_REG_WRITE && cnt_ok)
        begin
            for (int i = 0; i < 8; i++)
                if (8'(i) < cnt && (reg_idx + 8'(i)) < `TCCH_CFG_LEN)
                    cfg_mem[5'(reg_idx + 8'(i))] <= rx_buf[4 + i];
        end
    end

    // ==============================================
    // 256-byte memory; user half untouched by the store
    always_ff @(posedge clk_i)
    begin
        if (state_reg == tcch_pkg::TCCH_STORE)
            nvm_mem[(st_cal_reg ? `TCCH_NVM_CAL_BASE : `TCCH_NVM_CFG_BASE) + st_idx_reg]
                <= st_byte;
    end

    // ==============================================
    // Flip state byte, fixed once the fourth touch is in
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            calibration_axis_flip_reg <= 8'h00;
        else if (state_reg == tcch_pkg::TCCH_STORE && st_cal_reg && st_idx_reg == 8'h00)
        begin
            calibration_axis_flip_reg[7:3] <= 5'h00;
            calibration_axis_flip_reg[2] <= (dx < dy);
            calibration_axis_flip_reg[1] <= (dx < dy) ? (py_reg[1] < py_reg[0])
                                                      : (px_reg[1] < px_reg[0]);
            calibration_axis_flip_reg[0] <= (dx < dy) ? (px_reg[3] < px_reg[0])
                                                      : (py_reg[3] < py_reg[0]);
        end
    end

    // Flag outputs registered from the flip register's bits, one cycle behind
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            axis_swap_flag_o <= 1'b0;
            horizontal_mirror_flag_o <= 1'b0;
            vertical_mirror_flag_o <= 1'b0;
        end
        else
        begin
            axis_swap_flag_o <= calibration_axis_flip_reg[2];
            horizontal_mirror_flag_o <= calibration_axis_flip_reg[1];
            vertical_mirror_flag_o <= calibration_axis_flip_reg[0];
        end
    end
endmodule

// ---- tcch_chk.sv ----
`timescale 1ns/10ps
// =====
// Answer framing and calibration checks
module tcch_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic touch_valid_i,
    input wire logic calibrating_o,
    input wire logic axis_swap_flag_o,
    input wire logic horizontal_mirror_flag_o,
    input wire logic vertical_mirror_flag_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic tk;
    logic [2:0] idx_reg;
    logic [7:0] left_reg;
    logic [5:0] since_reg;
    assign tk = tx_valid_o && tx_ready_i;
    // Byte position, counting only bytes the host took; idle time since calibration
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {idx_reg, left_reg} <= '0;
            since_reg <= 6'h3F;
        end
        else
        begin
            since_reg <= calibrating_o ? 6'h00 : since_reg + 6'(since_reg != 6'h3F);
            if (tk)
                idx_reg <= (idx_reg < 3'h2 || left_reg > 8'h01) ?
                    idx_reg + 3'(idx_reg < 3'h4) : 3'h0;
            if (tk)
                left_reg <= (idx_reg == 3'h1) ? tx_data_o : left_reg - 8'h01;
        end
    end
    byte_held_a: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("answer byte changed before taken");
    header_byte_a: assert property (tk && idx_reg == 3'h0 |-> tx_data_o == 8'h55)
        else $error("answer header wrong");
    size_range_a: assert property (
        tk && idx_reg == 3'h1 |-> tx_data_o inside {[8'h02:8'h0A]})
        else $error("answer size out of range");
    status_code_a: assert property (
        tk && idx_reg == 3'h2 |-> tx_data_o inside {8'h00, 8'h01, 8'h03, 8'h04})
        else $error("unknown status code");
    cal_size_a: assert property (
        tk && idx_reg == 3'h1 && calibrating_o |-> tx_data_o == 8'h02)
        else $error("calibration ack size wrong");
    cal_start_a: assert property ($rose(calibrating_o) |-> ##[0:8] tx_valid_o)
        else $error("no ack on calibration start");
    touch_ack_a: assert property (touch_valid_i && calibrating_o |-> ##[1:40] tx_valid_o)
        else $error("no ack after calibration touch");
    flag_change_a: assert property (
        $changed({axis_swap_flag_o, horizontal_mirror_flag_o, vertical_mirror_flag_o})
        |-> since_reg < 6'h3F) else $error("flip flags moved outside calibration");
endmodule
bind tcch_handler tcch_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .touch_valid_i(touch_valid_i),
    .calibrating_o(calibrating_o), .axis_swap_flag_o(axis_swap_flag_o),
    .horizontal_mirror_flag_o(horizontal_mirror_flag_o),
    .vertical_mirror_flag_o(vertical_mirror_flag_o));

// ---- tcch_host.sv ----
`timescale 1ns/10ps
// =====
// Host end of the answer path
module tcch_host (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    output logic tx_ready_o
);
    // Slow host stalls every other cycle to stretch each byte
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tx_ready_o <= 1'b0;
        else
            tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
    end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
// =====
// Packet bench
module tb_top;
    typedef struct { logic [95:0] q; int nq; logic [95:0] r; int nr; } tcch_row_s;
    logic clk_i = 1'b0, rst_n_i = 1'b0, rx_valid_i = 1'b0, touch_valid_i = 1'b0, slow = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    logic [9:0] touch_x_i = 10'h000, touch_y_i = 10'h000;
    logic tx_valid_o, tx_ready_i, cal_o, swp_o, hm_o, vm_o;
    logic [7:0] tx_data_o;
    int failures = 0, comparisons = 0;
    // Touches as {x, y}; X runs backwards so it reads mirrored
    logic [19:0] pts [4] = '{{10'h384, 10'h0C8}, {10'h064, 10'h0D2},
        {10'h06E, 10'h320}, {10'h37A, 10'h316}};
    // Request bytes, then the whole expected answer
    tcch_row_s rows [12] = '{'{96'h550122, 3, 96'h5503002220, 5},
        '{96'h550621002102AABB, 8, 96'h55020021, 4},
        '{96'h550521002F010A, 7, 96'h55020021, 4},
        '{96'h5504207F2102, 6, 96'h55040020AABB, 6},
        '{96'h550420002109, 6, 96'h55020120, 4},
        '{96'h550421002100, 6, 96'h55020121, 4},
        '{96'h550428000109, 6, 96'h55020128, 4},
        '{96'h550110, 3, 96'h55020110, 4}, '{96'hA7, 1, 96'h550203A7, 4},
        '{96'h550320, 3, 96'h55020420, 4}, '{96'h550123, 3, 96'h55020023, 4},
        '{96'h550428330102, 6, 96'h55040028AABB, 6}};
    tcch_host u_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .tx_ready_o(tx_ready_i));
    tcch_handler #(.TIMEOUT_CYCLES(200)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .touch_valid_i(touch_valid_i),
        .touch_x_i(touch_x_i), .touch_y_i(touch_y_i), .calibrating_o(cal_o),
        .axis_swap_flag_o(swp_o), .horizontal_mirror_flag_o(hm_o), .vertical_mirror_flag_o(vm_o));
    always #4 clk_i = ~clk_i;
    task automatic check8(input string what, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    // Released lines show the inverse, never a stale copy
    task automatic xact(input tcch_row_s t);
        int n;
        for (int i = t.nq - 1; i >= 0; i--)
        begin
            @(posedge clk_i);
            #1 rx_valid_i = 1'b1;
            rx_data_i = t.q[8*i +: 8];
            @(posedge clk_i);
            #1 rx_valid_i = 1'b0;
            rx_data_i = ~t.q[8*i +: 8];
        end
        for (int i = t.nr - 1; i >= 0; i--)
        begin
            n = 0;
            do @(posedge clk_i) n++; while (!(tx_valid_o === 1'b1 && tx_ready_i) && n < 400);
            check8("answer byte", t.r[8*i +: 8], (n < 400) ? tx_data_o : ~t.r[8*i +: 8]);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        failures++;
        conclude();
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        foreach (rows[i])
        begin
            #1 slow = i[0];
            xact(rows[i]);
        end
        xact('{96'h55021404, 4, 96'h55020014, 4});
        check8("calibrating", 8'h01, {7'h00, cal_o});
        foreach (pts[k])
        begin
            @(posedge clk_i);
            #1 touch_valid_i = 1'b1;
            {touch_x_i, touch_y_i} = pts[k];
            @(posedge clk_i);
            #1 touch_valid_i = 1'b0;
            {touch_x_i, touch_y_i} = ~pts[k];
            xact('{96'h0, 0, 96'h55020014, 4});
        end
        xact('{96'h0, 0, 96'h55020014, 4});
        check8("flags after calibration", 8'h02, {4'h0, cal_o, swp_o, hm_o, vm_o});
        xact('{96'h550428004008, 6, 96'h550A0028A58016802F80E380, 12});
        xact('{96'h550428005101, 6, 96'h5503002802, 5});
        #1 rst_n_i = 1'b0;
        #1 check8("reset outputs", 8'h00, {tx_valid_o, cal_o, swp_o, hm_o, vm_o, 3'h0});
        check8("reset data", 8'h00, tx_data_o);
        // Release between edges; the first byte lands on the second edge after
        @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        xact(rows[0]);
        conclude();
    end
endmodule
